/* bench/tb_uart_fractional_baud_generator.sv */
`timescale 1ns/1ns
module tb_uart_fractional_baud_generator;
   logic        core_clk;
   logic        rst_b;
   logic [15:0] host_addr;
   logic        host_wr;
   logic        host_rd;
   logic [7:0]  host_wdata;
   logic [7:0]  host_rdata;
   logic        host_rvalid;
   logic        master_mode;
   logic [3:0]  rxd;
   logic [3:0]  txd;
   int          fail_count = 0;
   int          num_checks = 0;
   logic [15:0] cb;
   logic [7:0]  d1;
   logic [7:0]  d2;
   logic [8:0]  f1;
   logic [8:0]  f2;
   int          s1;
   int          s2;
   int          m;
   int          dv;
   int          fr4;
   int          pre;
   int          ex;

   ufbg_top i_ufbg_top (
      .core_clk(core_clk), .rst_b(rst_b), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .master_mode(master_mode), .rxd(rxd), .txd(txd)
   );
   ufbg_remote i_ufbg_remote (.core_clk(core_clk), .txd(txd), .rxd(rxd));

   // Clock, 100 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Expected bit time in clock cycles
   function automatic int bit_cycles(int dv, int fr4, int m, int pre, int mst);
      return ((16 >> m) * (16 * dv + fr4) / 16) * (pre ? 4 : 1) * (mst ? 1 : 2);
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One byte write, strobe left for the next task to change
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      host_rd = 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   // One byte read, checks valid and data the cycle after
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      host_addr = a;
      host_rd = 1'b1;
      host_wr = 1'b0;
      @(posedge core_clk);
      #1;
      chk({7'h00, host_rvalid, host_rdata}, {8'h01, exp});
   endtask

   task automatic idle();
      host_wr = 1'b0;
      host_rd = 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      #(90000 * 100);
      fail_count++;
      summarize();
   end

   initial
   begin
      host_addr = 16'h0000;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
      master_mode = 1'b1;
      rst_b = 1'b0;
      void'($urandom(51));
      repeat (5) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      // Reset values, status and refused places on every channel
      for (int ch = 0; ch < 4; ch++)
      begin
         cb = 16'(ch) << 9;
         rd_chk(cb + 16'h1, 8'h01);
         rd_chk(cb + 16'h2, 8'h00);
         rd_chk(cb + 16'h3, 8'h00);
         rd_chk(cb + 16'h4, 8'h00);
         rd_chk(cb + 16'h6, 8'h05);
         rd_chk(cb + 16'h7, 8'h00);
         rd_chk(cb | 16'h0800, 8'h00);
      end
      // Two frames back to back into channel 2, then one read too many
      idle();
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      i_ufbg_remote.send(2, d1, 16);
      i_ufbg_remote.send(2, d2, 16);
      repeat (30) @(posedge core_clk);
      #1;
      rd_chk(16'h0406, 8'h04);
      rd_chk(16'h0400, d1);
      rd_chk(16'h0400, d2);
      rd_chk(16'h0400, 8'h00);
      // Transmit timing over divisor, fraction, prescaler, source and factor;
      // channel 0 starts from its reset divisor, so no long countdown pends
      for (int n = 0; n < 6; n++)
      begin
         m = n % 3;
         dv = 1 + $urandom % 2;
         fr4 = (n == 0) ? 15 : ($urandom % 16) & ~((1 << m) - 1);
         pre = $urandom % 2;
         master_mode = (n > 1) ? 1'($urandom) : 1'b1;
         wr(16'h0001, 8'(dv));
         wr(16'h0002, 8'h00);
         wr(16'h0003, 8'(fr4));
         wr(16'h0004, 8'(pre << 7));
         wr(16'h0005, 8'(m));
         idle();
         repeat (5) @(posedge core_clk);
         #1;
         d1 = 8'($urandom) | 8'h01;
         d2 = 8'($urandom) | 8'h01;
         fork
            i_ufbg_remote.recv(0, f1, s1);
            begin
               wr(16'h0000, d1);
               wr(16'h0000, d2);
               idle();
            end
         join
         i_ufbg_remote.recv(0, f2, s2);
         ex = bit_cycles(dv, fr4, m, pre, master_mode);
         chk(16'(s1), 16'(ex));
         chk(16'(s2), 16'(ex));
         chk({7'h00, f1}, {8'h01, d1});
         chk({7'h00, f2}, {8'h01, d2});
         chk(16'(s2), 16'(s1));
      end
      // Random register contents, written and read back at once; run last,
      // as a large divisor left on channel 0 would stall a later transmit
      for (int ch = 0; ch < 4; ch++)
      begin
         cb = 16'(ch) << 9;
         d1 = 8'($urandom);
         wr(cb + 16'h1, d1);
         rd_chk(cb + 16'h1, d1);
         wr(cb + 16'h2, ~d1);
         rd_chk(cb + 16'h2, ~d1);
         wr(cb + 16'h3, d1);
         rd_chk(cb + 16'h3, d1 & 8'h0f);
         wr(cb + 16'h4, d1);
         rd_chk(cb + 16'h4, d1);
      end
      summarize();
   end
endmodule

/* bench/ufbg_remote.sv */
`timescale 1ns/1ns
module ufbg_remote #(
   parameter int NCH = 4
) (
   input  logic           core_clk, // System clock
   input  logic [NCH-1:0] txd,      // Lines from the block
   output logic [NCH-1:0] rxd       // Lines into the block
);
   // Lines idle high between frames
   initial rxd = '1;

   // Send one 8N1 frame LSB first, bit time in clock cycles
   task automatic send(input int ch, input logic [7:0] b, input int bc);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd[ch] <= fr[i];
         repeat (bc) @(posedge core_clk);
      end
   endtask

   // Catch one frame; data bit 0 must be high so the start bit can be timed
   task automatic recv(input int ch, output logic [8:0] b, output int slen);
      slen = 0;
      @(negedge txd[ch]);
      while (txd[ch] === 1'b0)
      begin
         @(posedge core_clk);
         #1;
         slen++;
      end
      // Sample data and stop at the middle of each bit
      repeat (slen / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++)
      begin
         if (i > 0)
            repeat (slen) @(posedge core_clk);
         #1;
         b[i] = txd[ch];
      end
   endtask
endmodule

/* bench/ufbg_top_properties.sv */
`timescale 1ns/1ns
`include "ufbg_defs.svh"
module ufbg_top_checker #(
   parameter int NCH = 4
) (
   input logic           core_clk,    // System clock
   input logic           rst_b,       // Async reset, active low
   input logic [15:0]    host_addr,   // Byte address
   input logic           host_wr,     // Write strobe
   input logic           host_rd,     // Read strobe
   input logic [7:0]     host_wdata,  // Write byte
   input logic [7:0]     host_rdata,  // Read byte
   input logic           host_rvalid, // Read byte valid
   input logic           master_mode, // Strap
   input logic [NCH-1:0] rxd,         // Serial inputs
   input logic [NCH-1:0] txd          // Serial outputs
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   // Write to a mapped offset, then a read of the same address
   sequence s_wr(logic [8:0] off);
      host_wr && host_addr[15:11] == 5'h00 && host_addr[8:0] == off;
   endsequence
   sequence s_rd_same;
      host_rd && !host_wr && host_addr == $past(host_addr);
   endsequence

   a_rvalid_after_rd: assert property (host_rd |=> host_rvalid)
      else $error("read strobe not answered next cycle");
   a_rvalid_has_cause: assert property (host_rvalid |-> $past(host_rd))
      else $error("read valid without a read strobe");
   a_rdata_holds: assert property (!host_rvalid |-> $stable(host_rdata))
      else $error("read byte moved without a read");
   a_unmapped_zero: assert property (host_rd && host_addr[15:11] != 5'h00
      |=> host_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_frac_upper: assert property (host_rd && host_addr[8:0] == `UFBG_OFF_FRAC
      |=> host_rdata[7:4] == 4'h0)
      else $error("fraction upper bits not zero");
   a_div_readback: assert property (s_wr(`UFBG_OFF_DIV_LO) ##1 s_rd_same
      |=> host_rdata == $past(host_wdata, 2))
      else $error("divisor low byte readback wrong");
   a_modem_readback: assert property (s_wr(`UFBG_OFF_MODEM) ##1 s_rd_same
      |=> host_rdata == $past(host_wdata, 2))
      else $error("modem control readback wrong");
   a_low_bit_min: assert property ($fell(txd[0]) |=> !txd[0] [*3])
      else $error("serial low level shorter than four cycles");
   a_high_bit_min: assert property ($rose(txd[0]) |=> txd[0] [*3])
      else $error("serial high level shorter than four cycles");
endmodule

bind ufbg_top ufbg_top_checker #(.NCH(NCH)) i_ufbg_top_checker (
   .core_clk(core_clk), .rst_b(rst_b), .host_addr(host_addr), .host_wr(host_wr),
   .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
   .host_rvalid(host_rvalid), .master_mode(master_mode), .rxd(rxd), .txd(txd)
);

/* logic/ufbg_baud_gen.sv */
`timescale 1ns/1ns
`include "ufbg_defs.svh"
module ufbg_baud_gen
   import ufbg_pkg::*;
(
   input  logic          core_clk,    // System clock
   input  logic          rst_b,       // Async reset, active low
   input  logic          src_en,      // Internal source clock enable
   input  ufbg_brg_cfg_s cfg,         // Divisor and prescaler setting
   output logic          sample_tick  // One pulse per sampling period
);
   logic [1:0]  pre_q, pre_d;
   logic        pre_en;
   logic [16:0] cnt_q, cnt_d;
   logic [3:0]  acc_q, acc_d;
   logic        tick_q, tick_d;
   logic [4:0]  frac_sum;
   logic [16:0] period;

   // Prescaler, divide by 1 or 4
   always_comb
   begin
      pre_d  = src_en ? pre_q + 2'h1 : pre_q;
      pre_en = src_en && (!cfg.pre_div4 || pre_q == 2'h3);
   end

   // Divisor counter with spread fractional cycles
   always_comb
   begin
      frac_sum = {1'b0, acc_q} + {1'b0, cfg.frac};
      period   = {(cfg.int_div == 16'h0000), cfg.int_div};
      cnt_d    = cnt_q;
      acc_d    = acc_q;
      tick_d   = 1'b0;
      if (pre_en)
      begin
         if (cnt_q == 17'h00000)
         begin
            tick_d = 1'b1;
            acc_d  = frac_sum[3:0];
            cnt_d  = period - 17'h00001 + {16'h0000, frac_sum[4]};
         end
         else
            cnt_d = cnt_q - 17'h00001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pre_q  <= 2'h0;
         cnt_q  <= 17'h00000;
         acc_q  <= 4'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q  <= pre_d;
         cnt_q  <= cnt_d;
         acc_q  <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign sample_tick = tick_q;
endmodule

/* logic/ufbg_defs.svh */
`ifndef UFBG_DEFS_SVH
`define UFBG_DEFS_SVH

// Channel count and storage sizes
`define UFBG_NCH          4
`define UFBG_FIFO_DEPTH   256

// Host address map: channel stride and per-channel offsets
`define UFBG_CH_STRIDE    16'h0200
`define UFBG_CH_LSB       9
`define UFBG_OFF_HOLD     9'h000
`define UFBG_OFF_DIV_LO   9'h001
`define UFBG_OFF_DIV_HI   9'h002
`define UFBG_OFF_FRAC     9'h003
`define UFBG_OFF_MODEM    9'h004
`define UFBG_OFF_SAMPLE   9'h005
`define UFBG_OFF_STATUS   9'h006

// Reset values
`define UFBG_RST_DIV_LO   8'h01
`define UFBG_RST_DIV_HI   8'h00
`define UFBG_RST_FRAC     4'h0
`define UFBG_RST_MODEM    8'h00
`define UFBG_RST_SAMPLE   2'h0

// Field positions
`define UFBG_MODEM_PRE_BIT 7
`define UFBG_SMP_8X_BIT    0
`define UFBG_SMP_4X_BIT    1
`define UFBG_ST_RX_EMPTY   0
`define UFBG_ST_RX_FULL    1
`define UFBG_ST_TX_EMPTY   2
`define UFBG_ST_TX_FULL    3

// Last phase of one bit time per sampling factor
`define UFBG_LAST_16X     4'hf
`define UFBG_LAST_8X      4'h7
`define UFBG_LAST_4X      4'h3

`endif

/* logic/ufbg_fifo.sv */
`timescale 1ns/1ns
module ufbg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256
) (
   input  logic             core_clk, // System clock
   input  logic             rst_b,    // Async reset, active low
   input  logic             push,     // Write one entry
   input  logic [WIDTH-1:0] wdata,    // Entry written
   input  logic             pop,      // Drop head entry
   output logic [WIDTH-1:0] rdata,    // Head entry
   output logic             empty,    // No entry held
   output logic             full      // All entries held
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             do_push, do_pop;

   // Pointer and level update
   always_comb
   begin
      do_push = push && !full;
      do_pop  = pop && !empty;
      wr_d    = do_push ? wr_q + 1'b1 : wr_q;
      rd_d    = do_pop ? rd_q + 1'b1 : rd_q;
      cnt_d   = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage, written at the write pointer
   always_ff @(posedge core_clk)
   begin
      if (do_push)
         mem_q[wr_q] <= wdata;
   end

   assign rdata = mem_q[rd_q];
   assign empty = (cnt_q == '0);
   assign full  = (cnt_q == (AW+1)'(DEPTH));
endmodule

/* logic/ufbg_pkg.sv */
package ufbg_pkg;

   // Baud generator setting of one channel
   typedef struct packed {
      logic [15:0] int_div;
      logic [3:0]  frac;
      logic        pre_div4;
      logic        eight_sel;
      logic        four_sel;
   } ufbg_brg_cfg_s;

   // Serial frame states, Gray coded
   typedef enum logic [1:0] {
      SER_IDLE  = 2'b00,
      SER_START = 2'b01,
      SER_DATA  = 2'b11,
      SER_STOP  = 2'b10
   } ufbg_ser_e;

endpackage

/* logic/ufbg_top.sv */
`timescale 1ns/1ns
`include "ufbg_defs.svh"
module ufbg_top
   import ufbg_pkg::*;
#(
   parameter int NCH   = `UFBG_NCH,
   parameter int DEPTH = `UFBG_FIFO_DEPTH
) (
   input  logic           core_clk,    // System clock, 10 MHz
   input  logic           rst_b,       // Async reset, active low
   input  logic [15:0]    host_addr,   // Byte address
   input  logic           host_wr,     // Write strobe
   input  logic           host_rd,     // Read strobe
   input  logic [7:0]     host_wdata,  // Write byte
   output logic [7:0]     host_rdata,  // Read byte
   output logic           host_rvalid, // Read byte valid
   input  logic           master_mode, // Strap, high for master
   input  logic [NCH-1:0] rxd,         // Serial inputs
   output logic [NCH-1:0] txd          // Serial outputs
);
   logic [8:0]     off;
   logic [1:0]     ch;
   logic           addr_ok;
   logic [NCH-1:0] wr_sel, hold_rd;

   logic [7:0]     div_lo_q [NCH], div_lo_d [NCH];
   logic [7:0]     div_hi_q [NCH], div_hi_d [NCH];
   logic [3:0]     frac_q   [NCH], frac_d   [NCH];
   logic [7:0]     modem_q  [NCH], modem_d  [NCH];
   logic [1:0]     smp_q    [NCH], smp_d    [NCH];
   ufbg_brg_cfg_s  cfg      [NCH];

   logic [NCH-1:0] tx_push, tx_pop, tx_empty, tx_full;
   logic [NCH-1:0] rx_push, rx_pop, rx_empty, rx_full;
   logic [7:0]     tx_head  [NCH];
   logic [7:0]     rx_head  [NCH];
   logic [NCH-1:0] tick;

   logic [NCH-1:0] rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_lvl_d;
   logic [2:0]     mst_sync_q;
   logic           mst_q, mst_d, half_q, src_en;
   logic [7:0]     rdata_q, rdata_d;
   logic           rvalid_q;

   ufbg_ser_e      tx_st_q  [NCH], tx_st_d [NCH];
   logic [7:0]     tx_sh_q  [NCH], tx_sh_d [NCH];
   logic [2:0]     tx_bit_q [NCH], tx_bit_d [NCH];
   logic [3:0]     tx_ph_q  [NCH], tx_ph_d [NCH];
   logic [NCH-1:0] txd_q, txd_d;

   ufbg_ser_e      rx_st_q  [NCH], rx_st_d [NCH];
   logic [7:0]     rx_sh_q  [NCH], rx_sh_d [NCH];
   logic [2:0]     rx_bit_q [NCH], rx_bit_d [NCH];
   logic [3:0]     rx_ph_q  [NCH], rx_ph_d [NCH];

   // Last phase of a bit time for the selected sampling factor
   function automatic logic [3:0] bit_last(input ufbg_brg_cfg_s c);
      if (c.eight_sel)
         bit_last = `UFBG_LAST_8X;
      else if (c.four_sel)
         bit_last = `UFBG_LAST_4X;
      else
         bit_last = `UFBG_LAST_16X;
   endfunction

   // Host address decode
   always_comb
   begin
      off     = host_addr[`UFBG_CH_LSB-1:0];
      ch      = host_addr[`UFBG_CH_LSB+1:`UFBG_CH_LSB];
      addr_ok = (host_addr[15:`UFBG_CH_LSB+2] == '0);
   end

   // Strap and serial input synchronisers, change taken when two agree
   always_comb
   begin
      mst_d    = (mst_sync_q[1] == mst_sync_q[2]) ? mst_sync_q[1] : mst_q;
      rx_lvl_d = rx_lvl_q;
      for (int i = 0; i < NCH; i++)
         if (rx_s2_q[i] == rx_s3_q[i])
            rx_lvl_d[i] = rx_s2_q[i];
      src_en   = mst_q || half_q;
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mst_sync_q <= 3'h0;
         mst_q      <= 1'b0;
         half_q     <= 1'b0;
         rx_s1_q    <= '1;
         rx_s2_q    <= '1;
         rx_s3_q    <= '1;
         rx_lvl_q   <= '1;
      end
      else
      begin
         mst_sync_q <= {mst_sync_q[1:0], master_mode};
         mst_q      <= mst_d;
         half_q     <= !half_q;
         rx_s1_q    <= rxd;
         rx_s2_q    <= rx_s1_q;
         rx_s3_q    <= rx_s2_q;
         rx_lvl_q   <= rx_lvl_d;
      end
   end

   // Host read mux and holding register strobes
   always_comb
   begin
      rdata_d = rdata_q;
      for (int i = 0; i < NCH; i++)
      begin
         wr_sel[i]  = host_wr && addr_ok && (ch == 2'(i));
         hold_rd[i] = host_rd && addr_ok && (ch == 2'(i)) && (off == `UFBG_OFF_HOLD);
         tx_push[i] = wr_sel[i] && (off == `UFBG_OFF_HOLD) && !tx_full[i];
         rx_pop[i]  = hold_rd[i] && !rx_empty[i];
      end
      if (host_rd)
      begin
         rdata_d = 8'h00;
         if (addr_ok)
            unique case (off)
               `UFBG_OFF_HOLD:   rdata_d = rx_empty[ch] ? 8'h00 : rx_head[ch];
               `UFBG_OFF_DIV_LO: rdata_d = div_lo_q[ch];
               `UFBG_OFF_DIV_HI: rdata_d = div_hi_q[ch];
               `UFBG_OFF_FRAC:   rdata_d = {4'h0, frac_q[ch]};
               `UFBG_OFF_MODEM:  rdata_d = modem_q[ch];
               `UFBG_OFF_SAMPLE: rdata_d = {6'h00, smp_q[ch]};
               `UFBG_OFF_STATUS: rdata_d = {4'h0, tx_full[ch], tx_empty[ch],
                                            rx_full[ch], rx_empty[ch]};
               default:          rdata_d = 8'h00;
            endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q  <= rdata_d;
         rvalid_q <= host_rd;
      end
   end

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      // Configuration register writes
      always_comb
      begin
         div_lo_d[c] = div_lo_q[c];
         div_hi_d[c] = div_hi_q[c];
         frac_d[c]   = frac_q[c];
         modem_d[c]  = modem_q[c];
         smp_d[c]    = smp_q[c];
         if (wr_sel[c])
            unique case (off)
               `UFBG_OFF_DIV_LO: div_lo_d[c] = host_wdata;
               `UFBG_OFF_DIV_HI: div_hi_d[c] = host_wdata;
               `UFBG_OFF_FRAC:   frac_d[c]   = host_wdata[3:0];
               `UFBG_OFF_MODEM:  modem_d[c]  = host_wdata;
               `UFBG_OFF_SAMPLE: smp_d[c]    = host_wdata[1:0];
               default:          ;
            endcase
         cfg[c].int_div   = {div_hi_q[c], div_lo_q[c]};
         cfg[c].frac      = frac_q[c];
         cfg[c].pre_div4  = modem_q[c][`UFBG_MODEM_PRE_BIT];
         cfg[c].eight_sel = smp_q[c][`UFBG_SMP_8X_BIT];
         cfg[c].four_sel  = smp_q[c][`UFBG_SMP_4X_BIT];
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            div_lo_q[c] <= `UFBG_RST_DIV_LO;
            div_hi_q[c] <= `UFBG_RST_DIV_HI;
            frac_q[c]   <= `UFBG_RST_FRAC;
            modem_q[c]  <= `UFBG_RST_MODEM;
            smp_q[c]    <= `UFBG_RST_SAMPLE;
         end
         else
         begin
            div_lo_q[c] <= div_lo_d[c];
            div_hi_q[c] <= div_hi_d[c];
            frac_q[c]   <= frac_d[c];
            modem_q[c]  <= modem_d[c];
            smp_q[c]    <= smp_d[c];
         end
      end

      // Per-channel FIFOs and generator
      ufbg_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
         .core_clk (core_clk),
         .rst_b    (rst_b),
         .push     (tx_push[c]),
         .wdata    (host_wdata),
         .pop      (tx_pop[c]),
         .rdata    (tx_head[c]),
         .empty    (tx_empty[c]),
         .full     (tx_full[c])
      );

      ufbg_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
         .core_clk (core_clk),
         .rst_b    (rst_b),
         .push     (rx_push[c]),
         .wdata    (rx_sh_q[c]),
         .pop      (rx_pop[c]),
         .rdata    (rx_head[c]),
         .empty    (rx_empty[c]),
         .full     (rx_full[c])
      );

      ufbg_baud_gen u_brg (
         .core_clk    (core_clk),
         .rst_b       (rst_b),
         .src_en      (src_en),
         .cfg         (cfg[c]),
         .sample_tick (tick[c])
      );

      // Transmitter, one bit per factor sampling ticks
      always_comb
      begin
         tx_st_d[c]  = tx_st_q[c];
         tx_sh_d[c]  = tx_sh_q[c];
         tx_bit_d[c] = tx_bit_q[c];
         tx_ph_d[c]  = tx_ph_q[c] + 4'h1;
         txd_d[c]    = txd_q[c];
         tx_pop[c]   = 1'b0;
         if (tick[c])
            unique case (tx_st_q[c])
               SER_IDLE:
               begin
                  tx_ph_d[c] = 4'h0;
                  if (!tx_empty[c])
                  begin
                     tx_pop[c]  = 1'b1;
                     tx_sh_d[c] = tx_head[c];
                     txd_d[c]   = 1'b0;
                     tx_st_d[c] = SER_START;
                  end
               end
               SER_START:
                  if (tx_ph_q[c] == bit_last(cfg[c]))
                  begin
                     tx_ph_d[c]  = 4'h0;
                     tx_bit_d[c] = 3'h0;
                     txd_d[c]    = tx_sh_q[c][0];
                     tx_st_d[c]  = SER_DATA;
                  end
               SER_DATA:
                  if (tx_ph_q[c] == bit_last(cfg[c]))
                  begin
                     tx_ph_d[c]  = 4'h0;
                     tx_sh_d[c]  = {1'b0, tx_sh_q[c][7:1]};
                     tx_bit_d[c] = tx_bit_q[c] + 3'h1;
                     txd_d[c]    = tx_sh_q[c][1];
                     if (tx_bit_q[c] == 3'h7)
                     begin
                        txd_d[c]   = 1'b1;
                        tx_st_d[c] = SER_STOP;
                     end
                  end
               SER_STOP:
                  if (tx_ph_q[c] == bit_last(cfg[c]))
                  begin
                     tx_ph_d[c] = 4'h0;
                     tx_st_d[c] = SER_IDLE;
                  end
            endcase
         else
            tx_ph_d[c] = tx_ph_q[c];
      end

      // Receiver, start checked mid-bit, data sampled per bit time
      always_comb
      begin
         rx_st_d[c]  = rx_st_q[c];
         rx_sh_d[c]  = rx_sh_q[c];
         rx_bit_d[c] = rx_bit_q[c];
         rx_ph_d[c]  = rx_ph_q[c] + 4'h1;
         rx_push[c]  = 1'b0;
         if (tick[c])
            unique case (rx_st_q[c])
               SER_IDLE:
               begin
                  rx_ph_d[c] = 4'h0;
                  if (!rx_lvl_q[c])
                     rx_st_d[c] = SER_START;
               end
               SER_START:
                  if (rx_ph_q[c] == (bit_last(cfg[c]) >> 1))
                  begin
                     rx_ph_d[c]  = 4'h0;
                     rx_bit_d[c] = 3'h0;
                     rx_st_d[c]  = rx_lvl_q[c] ? SER_IDLE : SER_DATA;
                  end
               SER_DATA:
                  if (rx_ph_q[c] == bit_last(cfg[c]))
                  begin
                     rx_ph_d[c]  = 4'h0;
                     rx_sh_d[c]  = {rx_lvl_q[c], rx_sh_q[c][7:1]};
                     rx_bit_d[c] = rx_bit_q[c] + 3'h1;
                     if (rx_bit_q[c] == 3'h7)
                        rx_st_d[c] = SER_STOP;
                  end
               SER_STOP:
                  if (rx_ph_q[c] == bit_last(cfg[c]))
                  begin
                     rx_ph_d[c] = 4'h0;
                     rx_push[c] = rx_lvl_q[c] && !rx_full[c];
                     rx_st_d[c] = SER_IDLE;
                  end
            endcase
         else
            rx_ph_d[c] = rx_ph_q[c];
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            tx_st_q[c]  <= SER_IDLE;
            tx_sh_q[c]  <= 8'h00;
            tx_bit_q[c] <= 3'h0;
            tx_ph_q[c]  <= 4'h0;
            txd_q[c]    <= 1'b1;
            rx_st_q[c]  <= SER_IDLE;
            rx_sh_q[c]  <= 8'h00;
            rx_bit_q[c] <= 3'h0;
            rx_ph_q[c]  <= 4'h0;
         end
         else
         begin
            tx_st_q[c]  <= tx_st_d[c];
            tx_sh_q[c]  <= tx_sh_d[c];
            tx_bit_q[c] <= tx_bit_d[c];
            tx_ph_q[c]  <= tx_ph_d[c];
            txd_q[c]    <= txd_d[c];
            rx_st_q[c]  <= rx_st_d[c];
            rx_sh_q[c]  <= rx_sh_d[c];
            rx_bit_q[c] <= rx_bit_d[c];
            rx_ph_q[c]  <= rx_ph_d[c];
         end
      end
   end

   assign host_rdata  = rdata_q;
   assign host_rvalid = rvalid_q;
   assign txd         = txd_q;
endmodule
